// [slm_pkg.sv]
package slm_pkg;
	// Register indices; byte address is four times the index
	localparam logic [17:0] IDX_G0_LOCK_MUTE = 18'h0e101;
	localparam logic [17:0] IDX_G0_RAMP_OFF  = 18'h0e103;
	localparam logic [17:0] IDX_G1_LOCK_MUTE = 18'h0e141;
	localparam logic [17:0] IDX_G1_RAMP_OFF  = 18'h0e143;
	localparam logic [17:0] IDX_INT_STATUS   = 18'h0e180;
	localparam logic [17:0] IDX_INT_MASK     = 18'h0e181;
	localparam int          ADDR_W           = 20;
	// Field positions
	localparam int          MUTE_LSB         = 0;
	localparam int          LOCK_LSB         = 8;
	localparam int          RAMP_OFF_BIT     = 0;
	localparam int          LOSS_LSB         = 0;
	localparam int          GAIN_LSB         = 8;
	// Reset values
	localparam logic [3:0]  MUTE_RST         = 4'h0;
	localparam logic [7:0]  LOCK_RST         = 8'h00;
	localparam logic [1:0]  RAMP_OFF_RST     = 2'h0;
	localparam logic [15:0] INT_RST          = 16'h0000;
	// Gain ramp: 256 steps from silence to unity
	localparam int          GAIN_W           = 9;
	localparam logic [8:0]  GAIN_UNITY       = 9'h100;
	localparam logic [8:0]  GAIN_ZERO        = 9'h000;
	localparam int          CLK_PERIOD_NS    = 20;
	localparam int          RAMP_STEP_NS     = 20000;
	localparam int          RAMP_STEP_CYC    = (RAMP_STEP_NS / CLK_PERIOD_NS < 1) ? 1 : RAMP_STEP_NS / CLK_PERIOD_NS;
	localparam int          SAMPLE_W         = 24;
	localparam logic [1:0]  RESP_OKAY        = 2'h0;
	localparam logic [1:0]  RESP_SLVERR      = 2'h2;
	typedef enum logic [1:0] {
		RAMP_HOLD = 2'b00,
		RAMP_DOWN = 2'b01,
		RAMP_UP   = 2'b10
	} slm_ramp_state_type;
endpackage : slm_pkg

// [slm_ramp_if.sv]
`timescale 1ns/100ps
`default_nettype none
interface slm_ramp_if;
	logic                           tick;
	logic                           muteReq;
	logic                           abrupt;
	logic [slm_pkg::GAIN_W-1:0]     gain;
	modport ctl  (output tick, output muteReq, output abrupt, input gain);
	modport ramp (input tick, input muteReq, input abrupt, output gain);
endinterface : slm_ramp_if
`default_nettype wire

// [slm_ramp.sv]
`timescale 1ns/100ps
`default_nettype none
module slm_ramp (
	input  wire logic  core_clk,
	input  wire logic  rst_b,
	slm_ramp_if.ramp   rif
);
	logic [slm_pkg::GAIN_W-1:0]     gain_q;
	logic [slm_pkg::GAIN_W-1:0]     gain_d;
	slm_pkg::slm_ramp_state_type    dir;
	wire                            atZero  = (gain_q == slm_pkg::GAIN_ZERO);
	wire                            atUnity = (gain_q == slm_pkg::GAIN_UNITY);

	always_comb begin
		if (rif.muteReq && !atZero)
			dir = slm_pkg::RAMP_DOWN;
		else if (!rif.muteReq && !atUnity)
			dir = slm_pkg::RAMP_UP;
		else
			dir = slm_pkg::RAMP_HOLD;
	end

	always_comb begin
		gain_d = gain_q;
		if (rif.abrupt) begin
			gain_d = rif.muteReq ? slm_pkg::GAIN_ZERO : slm_pkg::GAIN_UNITY;
		end else if (rif.tick) begin
			case (dir)
				slm_pkg::RAMP_DOWN: gain_d = gain_q - 9'h001;
				slm_pkg::RAMP_UP:   gain_d = gain_q + 9'h001;
				slm_pkg::RAMP_HOLD: gain_d = gain_q;
				default:            gain_d = gain_q;
			endcase
		end
	end

	// Starts silent: no converter is locked out of reset
	always_ff @(posedge core_clk) begin
		if (!rst_b)
			gain_q <= slm_pkg::GAIN_ZERO;
		else
			gain_q <= gain_d;
	end

	assign rif.gain = gain_q;
endmodule : slm_ramp
`default_nettype wire

// [slm_lock_mute.sv]
`timescale 1ns/100ps
`default_nettype none
module slm_lock_mute #(
	parameter bit HAS_CONVERTERS = 1'b1
) (
	input  wire logic                          core_clk,
	input  wire logic                          rst_b,
	// AXI4-Lite slave
	input  wire logic [slm_pkg::ADDR_W-1:0]    s_axi_awaddr,
	input  wire logic                          s_axi_awvalid,
	output logic                               s_axi_awready,
	input  wire logic [31:0]                   s_axi_wdata,
	input  wire logic [3:0]                    s_axi_wstrb,
	input  wire logic                          s_axi_wvalid,
	output logic                               s_axi_wready,
	output logic [1:0]                         s_axi_bresp,
	output logic                               s_axi_bvalid,
	input  wire logic                          s_axi_bready,
	input  wire logic [slm_pkg::ADDR_W-1:0]    s_axi_araddr,
	input  wire logic                          s_axi_arvalid,
	output logic                               s_axi_arready,
	output logic [31:0]                        s_axi_rdata,
	output logic [1:0]                         s_axi_rresp,
	output logic                               s_axi_rvalid,
	input  wire logic                          s_axi_rready,
	// Converter lock indications, one per stereo converter
	input  wire logic [7:0]                    convLocked,
	// Time-multiplexed converter output stream
	input  wire logic [slm_pkg::SAMPLE_W-1:0]  inSample,
	input  wire logic [2:0]                    inConv,
	input  wire logic                          inRight,
	input  wire logic                          inValid,
	output logic [slm_pkg::SAMPLE_W-1:0]       outSample,
	output logic [2:0]                         outConv,
	output logic                               outRight,
	output logic                               outValid,
	output logic                               irq
);
	function automatic logic regHit(input logic [slm_pkg::ADDR_W-1:0] addr, input logic [17:0] idx);
		regHit = (addr[slm_pkg::ADDR_W-1:2] == idx) && (addr[1:0] == 2'b00);
	endfunction : regHit

	logic [3:0]                        muteG0_q;
	logic [3:0]                        muteG1_q;
	logic [1:0]                        rampOff_q;
	logic [7:0]                        lock_q;
	logic [15:0]                       intStat_q;
	logic [15:0]                       intMask_q;
	logic [15:0]                       intStat_d;
	logic                              awHeld_q;
	logic                              wHeld_q;
	logic [slm_pkg::ADDR_W-1:0]        awAddr_q;
	logic [31:0]                       wData_q;
	logic [3:0]                        wStrb_q;
	logic [15:0]                       tickCnt_q;
	logic                              tick_q;
	logic [slm_pkg::GAIN_W-1:0]        gainAll [8];

	// Write channel
	wire awTaken   = s_axi_awvalid && s_axi_awready;
	wire wTaken    = s_axi_wvalid && s_axi_wready;
	wire awHave    = awHeld_q || awTaken;
	wire wHave     = wHeld_q || wTaken;
	wire doWrite   = awHave && wHave && !s_axi_bvalid;
	wire [slm_pkg::ADDR_W-1:0] wAddr = awHeld_q ? awAddr_q : s_axi_awaddr;
	wire [31:0]    wData   = wHeld_q ? wData_q : s_axi_wdata;
	wire [3:0]     wStrb   = wHeld_q ? wStrb_q : s_axi_wstrb;
	wire           loLane  = wStrb[0];
	wire           hiLane  = wStrb[1];
	wire           wrG0Lm  = doWrite && regHit(wAddr, slm_pkg::IDX_G0_LOCK_MUTE);
	wire           wrG0Ro  = doWrite && regHit(wAddr, slm_pkg::IDX_G0_RAMP_OFF);
	wire           wrG1Lm  = doWrite && regHit(wAddr, slm_pkg::IDX_G1_LOCK_MUTE);
	wire           wrG1Ro  = doWrite && regHit(wAddr, slm_pkg::IDX_G1_RAMP_OFF);
	wire           wrStat  = doWrite && regHit(wAddr, slm_pkg::IDX_INT_STATUS);
	wire           wrMask  = doWrite && regHit(wAddr, slm_pkg::IDX_INT_MASK);
	wire           wrAny   = wrG0Lm || wrG0Ro || wrG1Lm || wrG1Ro || wrStat || wrMask;
	// Without converters the mute and ramp bits do not store at all
	wire           convWr  = HAS_CONVERTERS && loLane;

	// Read channel
	wire arTaken   = s_axi_arvalid && s_axi_arready;
	wire rdG0Lm    = regHit(s_axi_araddr, slm_pkg::IDX_G0_LOCK_MUTE);
	wire rdG0Ro    = regHit(s_axi_araddr, slm_pkg::IDX_G0_RAMP_OFF);
	wire rdG1Lm    = regHit(s_axi_araddr, slm_pkg::IDX_G1_LOCK_MUTE);
	wire rdG1Ro    = regHit(s_axi_araddr, slm_pkg::IDX_G1_RAMP_OFF);
	wire rdStat    = regHit(s_axi_araddr, slm_pkg::IDX_INT_STATUS);
	wire rdMask    = regHit(s_axi_araddr, slm_pkg::IDX_INT_MASK);
	wire rdAny     = rdG0Lm || rdG0Ro || rdG1Lm || rdG1Ro || rdStat || rdMask;
	wire [15:0]    g0Word  = {4'h0, lock_q[3:0], 4'h0, muteG0_q};
	wire [15:0]    g1Word  = {4'h0, lock_q[7:4], 4'h0, muteG1_q};
	wire [15:0]    rdWord  = rdG0Lm ? g0Word :
	                         rdG1Lm ? g1Word :
	                         rdG0Ro ? {15'h0000, rampOff_q[0]} :
	                         rdG1Ro ? {15'h0000, rampOff_q[1]} :
	                         rdStat ? intStat_q :
	                         rdMask ? intMask_q : 16'h0000;

	// Lock supervision and interrupt events
	wire [7:0]     lockNow  = HAS_CONVERTERS ? convLocked : 8'h00;
	wire [7:0]     lossEvt  = lock_q & ~lockNow;
	wire [7:0]     gainEvt  = ~lock_q & lockNow;
	wire [15:0]    evtAll   = {gainEvt, lossEvt};
	wire [15:0]    clrBits  = wrStat ? {(hiLane ? wData[15:8] : 8'h00), (loLane ? wData[7:0] : 8'h00)} : 16'h0000;

	always_comb begin
		// New events win over a simultaneous write-one-to-clear
		intStat_d = (intStat_q & ~clrBits) | evtAll;
	end

	always_ff @(posedge core_clk) begin
		if (!rst_b) begin
			awHeld_q      <= 1'b0;
			wHeld_q       <= 1'b0;
			s_axi_awready <= 1'b0;
			s_axi_wready  <= 1'b0;
			s_axi_bvalid  <= 1'b0;
			s_axi_bresp   <= slm_pkg::RESP_OKAY;
		end else begin
			awHeld_q      <= awHave && !doWrite;
			wHeld_q       <= wHave && !doWrite;
			// Readies stay low while an answer is due, so a taken pair always gets its answer next edge
			s_axi_awready <= !awHave && !(s_axi_bvalid && !s_axi_bready);
			s_axi_wready  <= !wHave && !(s_axi_bvalid && !s_axi_bready);
			if (doWrite) begin
				s_axi_bvalid <= 1'b1;
				s_axi_bresp  <= wrAny ? slm_pkg::RESP_OKAY : slm_pkg::RESP_SLVERR;
			end else if (s_axi_bready) begin
				s_axi_bvalid <= 1'b0;
			end
		end
	end

	always_ff @(posedge core_clk) begin
		if (awTaken)
			awAddr_q <= s_axi_awaddr;
		if (wTaken) begin
			wData_q <= s_axi_wdata;
			wStrb_q <= s_axi_wstrb;
		end
	end

	always_ff @(posedge core_clk) begin
		if (!rst_b) begin
			s_axi_arready <= 1'b0;
			s_axi_rvalid  <= 1'b0;
			s_axi_rdata   <= 32'h00000000;
			s_axi_rresp   <= slm_pkg::RESP_OKAY;
		end else if (arTaken) begin
			s_axi_arready <= 1'b0;
			s_axi_rvalid  <= 1'b1;
			s_axi_rdata   <= {16'h0000, rdWord};
			s_axi_rresp   <= rdAny ? slm_pkg::RESP_OKAY : slm_pkg::RESP_SLVERR;
		end else if (s_axi_rvalid && s_axi_rready) begin
			s_axi_rvalid  <= 1'b0;
			s_axi_arready <= 1'b1;
		end else begin
			s_axi_arready <= !s_axi_rvalid;
		end
	end

	// Control registers; mute and ramp bits take the low lane only, the interrupt mask takes both lanes
	always_ff @(posedge core_clk) begin
		if (!rst_b) begin
			muteG0_q  <= slm_pkg::MUTE_RST;
			muteG1_q  <= slm_pkg::MUTE_RST;
			rampOff_q <= slm_pkg::RAMP_OFF_RST;
			intMask_q <= slm_pkg::INT_RST;
			intStat_q <= slm_pkg::INT_RST;
			lock_q    <= slm_pkg::LOCK_RST;
			irq       <= 1'b0;
		end else begin
			if (wrG0Lm && convWr)
				muteG0_q <= wData[3:0];
			if (wrG1Lm && convWr)
				muteG1_q <= wData[3:0];
			if (wrG0Ro && convWr)
				rampOff_q[0] <= wData[slm_pkg::RAMP_OFF_BIT];
			if (wrG1Ro && convWr)
				rampOff_q[1] <= wData[slm_pkg::RAMP_OFF_BIT];
			if (wrMask && loLane)
				intMask_q[7:0] <= wData[7:0];
			if (wrMask && hiLane)
				intMask_q[15:8] <= wData[15:8];
			intStat_q <= intStat_d;
			lock_q    <= lockNow;
			irq       <= |(intStat_d & intMask_q);
		end
	end

	// Ramp step enable divider
	always_ff @(posedge core_clk) begin
		if (!rst_b) begin
			tickCnt_q <= 16'h0000;
			tick_q    <= 1'b0;
		end else if (tickCnt_q == 16'(slm_pkg::RAMP_STEP_CYC - 1)) begin
			tickCnt_q <= 16'h0000;
			tick_q    <= 1'b1;
		end else begin
			tickCnt_q <= tickCnt_q + 16'h0001;
			tick_q    <= 1'b0;
		end
	end

	// One gain ramp per converter
	for (genvar n = 0; n < 8; n++) begin : gConv
		slm_ramp_if rif ();
		wire grp    = (n >= 4);
		wire swMute = grp ? muteG1_q[n%4] : muteG0_q[n%4];
		wire rOff   = rampOff_q[grp];
		assign rif.tick    = tick_q;
		// Soft mutes are dropped while the group's ramp is disabled
		assign rif.muteReq = HAS_CONVERTERS && (!lock_q[n] || (swMute && !rOff));
		assign rif.abrupt  = HAS_CONVERTERS ? rOff : 1'b1;
		assign gainAll[n]  = rif.gain;
		slm_ramp uRamp (
			.core_clk (core_clk),
			.rst_b    (rst_b),
			.rif      (rif)
		);
	end

	// Gain applied to the stream; unity is an exact pass-through
	wire [slm_pkg::GAIN_W-1:0] selGain = gainAll[inConv];
	wire signed [33:0]         prod    = $signed(inSample) * $signed({1'b0, selGain});

	always_ff @(posedge core_clk) begin
		if (!rst_b) begin
			outSample <= '0;
			outConv   <= 3'h0;
			outRight  <= 1'b0;
			outValid  <= 1'b0;
		end else begin
			outSample <= prod[slm_pkg::GAIN_LSB +: slm_pkg::SAMPLE_W];
			outConv   <= inConv;
			outRight  <= inRight;
			outValid  <= inValid;
		end
	end
endmodule : slm_lock_mute
`default_nettype wire

// [slm_lock_mute_checker.sv]
`timescale 1ns/100ps
`default_nettype none
module slm_lock_mute_checker (
	input wire logic        core_clk,
	input wire logic        rst_b,
	input wire logic        s_axi_awvalid,
	input wire logic        s_axi_awready,
	input wire logic        s_axi_wvalid,
	input wire logic        s_axi_wready,
	input wire logic [1:0]  s_axi_bresp,
	input wire logic        s_axi_bvalid,
	input wire logic        s_axi_bready,
	input wire logic        s_axi_arvalid,
	input wire logic        s_axi_arready,
	input wire logic [31:0] s_axi_rdata,
	input wire logic        s_axi_rvalid,
	input wire logic        s_axi_rready,
	input wire logic [2:0]  inConv,
	input wire logic        inValid,
	input wire logic [2:0]  outConv,
	input wire logic        outValid,
	input wire logic        irq
);
	default clocking @(posedge core_clk); endclocking
	default disable iff (!rst_b);
	wr_answer_a: assert property (s_axi_awvalid && s_axi_awready && s_axi_wvalid && s_axi_wready |=> s_axi_bvalid)
		else $error("write answer missing");
	b_holds_a: assert property (s_axi_bvalid && !s_axi_bready |=> s_axi_bvalid && $stable(s_axi_bresp))
		else $error("write answer dropped");
	rd_answer_a: assert property (s_axi_arvalid && s_axi_arready |=> s_axi_rvalid && !s_axi_arready)
		else $error("read answer missing");
	r_holds_a: assert property (s_axi_rvalid && !s_axi_rready |=> s_axi_rvalid && $stable(s_axi_rdata))
		else $error("read data dropped");
	upper_zero_a: assert property (s_axi_rvalid |-> s_axi_rdata[31:16] == 16'h0000)
		else $error("reserved read bits set");
	stream_delay_a: assert property (inValid |=> outValid && outConv == $past(inConv))
		else $error("stream sample lost");
	stream_idle_a: assert property (!inValid |=> !outValid)
		else $error("stream sample invented");
	reset_quiet_a: assert property ($rose(rst_b) |-> !irq && !s_axi_bvalid && !s_axi_rvalid && !outValid)
		else $error("outputs active after reset");
endmodule : slm_lock_mute_checker
bind slm_lock_mute slm_lock_mute_checker chk (.core_clk, .rst_b, .s_axi_awvalid, .s_axi_awready, .s_axi_wvalid,
	.s_axi_wready, .s_axi_bresp, .s_axi_bvalid, .s_axi_bready, .s_axi_arvalid, .s_axi_arready, .s_axi_rdata,
	.s_axi_rvalid, .s_axi_rready, .inConv, .inValid, .outConv, .outValid, .irq);
`default_nettype wire

// [slm_lock_mute_bench.sv]
`timescale 1ns/100ps
`default_nettype none
module slm_lock_mute_bench;
	logic        core_clk, rst_b, irq, inRight, inValid, outRight, outValid;
	logic [19:0] s_axi_awaddr, s_axi_araddr;
	logic [31:0] s_axi_wdata, s_axi_rdata, d, r;
	logic [3:0]  s_axi_wstrb;
	logic [1:0]  s_axi_bresp, s_axi_rresp, rsp;
	logic        s_axi_awvalid, s_axi_awready, s_axi_wvalid, s_axi_wready, s_axi_bvalid, s_axi_bready;
	logic        s_axi_arvalid, s_axi_arready, s_axi_rvalid, s_axi_rready;
	logic [7:0]  convLocked;
	logic [23:0] inSample, outSample, seen;
	logic [2:0]  inConv, outConv;
	int          fails, n_tests, seed;
	logic [19:0] ra [4] = '{20'h38404, 20'h3840c, 20'h38504, 20'h3850c};
	slm_lock_mute DUT (.core_clk, .rst_b, .s_axi_awaddr, .s_axi_awvalid, .s_axi_awready, .s_axi_wdata, .s_axi_wstrb,
		.s_axi_wvalid, .s_axi_wready, .s_axi_bresp, .s_axi_bvalid, .s_axi_bready, .s_axi_araddr, .s_axi_arvalid,
		.s_axi_arready, .s_axi_rdata, .s_axi_rresp, .s_axi_rvalid, .s_axi_rready, .convLocked, .inSample, .inConv,
		.inRight, .inValid, .outSample, .outConv, .outRight, .outValid, .irq);
	initial begin
		core_clk = 1'b0;
		forever #10 core_clk = ~core_clk;
	end
	task automatic chk(input string nm, input logic [31:0] sn, input logic [31:0] ex);
		n_tests++;
		if (sn !== ex) begin
			fails++;
			$display("MISMATCH %s expected %h seen %h", nm, ex, sn);
		end
	endtask : chk
	function automatic logic [31:0] lmWord(input logic [3:0] lk, input logic [3:0] mt);
		return {20'h0, lk, 4'h0, mt};
	endfunction : lmWord
	task automatic tally_and_finish;
		$display("Counts: %0d compared, %0d mismatched", n_tests, fails);
		if (fails == 0 && n_tests > 0) begin
			$display("All checks passed");
		end else begin
			$display("Checks failed");
		end
		$finish;
	endtask : tally_and_finish
	// Called just after an edge; address and data stay up until each is taken
	task automatic wr(input logic [19:0] a, input logic [31:0] v);
		bit ad;
		bit wd;
		ad = 1'b0;
		wd = 1'b0;
		s_axi_awaddr <= a;
		s_axi_wdata <= v;
		s_axi_awvalid <= 1'b1;
		s_axi_wvalid <= 1'b1;
		s_axi_bready <= 1'b1;
		while (!(ad && wd)) begin
			@(posedge core_clk);
			if (s_axi_awready && !ad) begin
				ad = 1'b1;
				s_axi_awvalid <= 1'b0;
			end
			if (s_axi_wready && !wd) begin
				wd = 1'b1;
				s_axi_wvalid <= 1'b0;
			end
		end
		do @(posedge core_clk); while (!s_axi_bvalid);
		rsp = s_axi_bresp;
		s_axi_bready <= 1'b0;
		// One edge between calls so no strobe is lowered and raised in one step
		@(posedge core_clk);
	endtask : wr
	task automatic rd(input logic [19:0] a);
		s_axi_araddr <= a;
		s_axi_arvalid <= 1'b1;
		s_axi_rready <= 1'b1;
		do @(posedge core_clk); while (!s_axi_arready);
		s_axi_arvalid <= 1'b0;
		do @(posedge core_clk); while (!s_axi_rvalid);
		r = s_axi_rdata;
		rsp = s_axi_rresp;
		s_axi_rready <= 1'b0;
		@(posedge core_clk);
	endtask : rd
	task automatic st(input logic [2:0] c, input logic [23:0] s);
		inSample <= s;
		inConv <= c;
		inRight <= s[0];
		inValid <= 1'b1;
		@(posedge core_clk);
		inValid <= 1'b0;
		@(posedge core_clk);
		seen = outSample;
		chk("streamSide", 32'({outValid, outRight, outConv}), 32'({1'b1, s[0], c}));
	endtask : st
	initial begin
		repeat (50000) @(posedge core_clk);
		fails++;
		tally_and_finish();
	end
	initial begin
		seed = 32'h663d5824;
		{fails, n_tests} = '0;
		{rst_b, s_axi_awaddr, s_axi_araddr, s_axi_wdata, s_axi_awvalid, s_axi_wvalid, s_axi_bready} = '0;
		{s_axi_arvalid, s_axi_rready, convLocked, inSample, inConv, inRight, inValid} = '0;
		s_axi_wstrb = 4'hf;
		repeat (4) @(posedge core_clk);
		rst_b <= 1'b1;
		@(posedge core_clk);
		foreach (ra[i]) begin
			rd(ra[i]);
			chk("resetValue", r, 32'h0);
		end
		$display("test reset values done");
		repeat (6) begin
			convLocked <= 8'($random(seed));
			d = $random(seed);
			for (int g = 0; g < 2; g++) begin
				wr(ra[2*g], d);
				rd(ra[2*g]);
				chk("lockMute", r, lmWord(convLocked[4*g+:4], d[3:0]));
				wr(ra[2*g+1], d);
				rd(ra[2*g+1]);
				chk("rampOff", r, {31'h0, d[0]});
			end
		end
		$display("test register access done");
		wr(20'h38408, 32'hffffffff);
		chk("wrResp", 32'(rsp), 32'(slm_pkg::RESP_SLVERR));
		rd(20'h38408);
		chk("rdUnmapped", r, 32'h0);
		chk("rdResp", 32'(rsp), 32'(slm_pkg::RESP_SLVERR));
		$display("test unmapped done");
		convLocked <= 8'hff;
		wr(ra[1], 32'h1);
		wr(ra[0], 32'hf);
		repeat (4) @(posedge core_clk);
		for (int c = 0; c < 4; c++) begin
			d = $random(seed);
			st(c[2:0], d[23:0]);
			chk("abruptUnity", 32'(seen), 32'(d[23:0]));
		end
		convLocked[2] <= 1'b0;
		repeat (4) @(posedge core_clk);
		st(3'd2, 24'h7fffff);
		chk("lossMute", 32'(seen), 32'h0);
		st(3'd1, 24'h123456);
		chk("otherLive", 32'(seen), 32'h123456);
		$display("test abrupt mute done");
		wr(ra[3], 32'h1);
		wr(ra[2], 32'h0);
		repeat (4) @(posedge core_clk);
		st(3'd4, 24'h010000);
		chk("g1Unity", 32'(seen), 32'h10000);
		wr(ra[3], 32'h0);
		wr(ra[2], 32'h1);
		// A few ramp ticks only: the gain must sit just below unity
		repeat (2500) @(posedge core_clk);
		st(3'd4, 24'h010000);
		chk("rampPartial", 32'(seen > 24'h00fa00 && seen < 24'h010000), 32'h1);
		st(3'd5, 24'h010000);
		chk("rampOther", 32'(seen), 32'h10000);
		$display("test ramp done");
		wr(20'h38604, 32'hff);
		wr(20'h38600, 32'hffff);
		repeat (2) @(posedge core_clk);
		chk("irqClear", 32'(irq), 32'h0);
		convLocked[5] <= 1'b0;
		repeat (4) @(posedge core_clk);
		chk("irqSet", 32'(irq), 32'h1);
		rd(20'h38600);
		chk("status", r, 32'h20);
		wr(20'h38604, 32'h0);
		repeat (2) @(posedge core_clk);
		chk("irqMasked", 32'(irq), 32'h0);
		wr(20'h38604, 32'hff);
		repeat (2) @(posedge core_clk);
		chk("irqUnmask", 32'(irq), 32'h1);
		wr(20'h38600, 32'h20);
		repeat (2) @(posedge core_clk);
		chk("irqW1c", 32'(irq), 32'h0);
		$display("test interrupt done");
		tally_and_finish();
	end
endmodule : slm_lock_mute_bench
`default_nettype wire
